/* rtl/lsr_regs.vh */
`ifndef LSR_REGS_VH
`define LSR_REGS_VH

// Shift chain geometry
`define LSR_CHAIN_DEPTH   16
`define LSR_TAP_AW        4
`define LSR_LAST_STAGE    15

// RAM configuration codes
`define LSR_CFG_W         3
`define LSR_CFG_S16X1     3'h0
`define LSR_CFG_S32X1     3'h1
`define LSR_CFG_S64X1     3'h2
`define LSR_CFG_D16X1     3'h3
`define LSR_CFG_S16X2     3'h4
`define LSR_CFG_S32X2     3'h5
`define LSR_CFG_S16X4     3'h6

// RAM array geometry: 64 cells, address and data widths
`define LSR_RAM_CELLS     64
`define LSR_RAM_AW        6
`define LSR_RAM_DW        4

// Initial contents of all cells
`define LSR_RAM_INIT      64'h0000000000000000

`endif

/* rtl/lsr_lut_memory.v */
// Operation
// - Sixteen-stage chain, any stage tapped by address
// - Shift strobe loads serial bit, pushes deeper
// - Tap zero shows bit just shifted in
// - Tap read is combinational, follows address
// - Last stage output always shows stage fifteen
// - Single-port RAM of 16, 32, 64 bits
// - Dual-port 16x1 with second read address
// - One data bit in and out per port
// - Wide 16x2, 32x2, 16x4 share address
// - Write only with strobe on clock edge
// - Primary output shows newly written word
// - Both read ports see same cells
// - Contents start zero, reset leaves them alone
`timescale 1ns/100ps
`include "lsr_regs.vh"

module lsr_lut_memory #(
    parameter [`LSR_RAM_CELLS-1:0] RAM_INIT = `LSR_RAM_INIT
) (
    // Clock and reset
    input  wire                       clk_sys,
    input  wire                       rst_b,
    // Shift chain
    input  wire                       shift_write_strobe,
    input  wire                       serial_bit_in,
    input  wire [`LSR_TAP_AW-1:0]     tap_address,
    output wire                       tap_out,
    output wire                       last_stage_out,
    // RAM
    input  wire [`LSR_CFG_W-1:0]      ram_config,
    input  wire                       ram_write_strobe,
    input  wire [`LSR_RAM_AW-1:0]     ram_address,
    input  wire [`LSR_RAM_AW-1:0]     second_read_address,
    input  wire [`LSR_RAM_DW-1:0]     ram_data_in,
    output wire [`LSR_RAM_DW-1:0]     primary_read_out,
    output wire                       secondary_read_out
);

////////////////////////////////////////////////////////////////////////////////
// Shift chain, no reset on contents

reg  [`LSR_CHAIN_DEPTH-1:0] chain_r;
reg  [`LSR_CHAIN_DEPTH-1:0] chain_nxt;

initial chain_r = {`LSR_CHAIN_DEPTH{1'b0}};

// Select one stage of the chain
function lsr_tap;
    input [`LSR_CHAIN_DEPTH-1:0] chain;
    input [`LSR_TAP_AW-1:0]      sel;
    begin
        lsr_tap = chain[sel];
    end
endfunction

// Next chain value: shift in at stage 0, else hold
always @* begin
    chain_nxt = chain_r;
    if (shift_write_strobe) begin
        chain_nxt = {chain_r[`LSR_CHAIN_DEPTH-2:0], serial_bit_in};
    end
end

// Reset deliberately absent: contents survive rst_b
always @(posedge clk_sys) begin
    chain_r <= chain_nxt;
end

// Tap read follows the address with no clock
assign tap_out        = lsr_tap(chain_r, tap_address);
assign last_stage_out = chain_r[`LSR_LAST_STAGE];

////////////////////////////////////////////////////////////////////////////////
// RAM address and width decode

// Mask address to the depth of the configuration
function [`LSR_RAM_AW-1:0] lsr_mask_addr;
    input [`LSR_CFG_W-1:0]  cfg;
    input [`LSR_RAM_AW-1:0] addr;
    begin
        case (cfg)
            `LSR_CFG_S32X1,
            `LSR_CFG_S32X2: lsr_mask_addr = {1'b0, addr[4:0]};
            `LSR_CFG_S64X1: lsr_mask_addr = addr;
            default:        lsr_mask_addr = {2'b00, addr[3:0]};
        endcase
    end
endfunction

// Mask of data lanes in use for the configuration
function [`LSR_RAM_DW-1:0] lsr_lane_mask;
    input [`LSR_CFG_W-1:0] cfg;
    begin
        case (cfg)
            `LSR_CFG_S16X2,
            `LSR_CFG_S32X2: lsr_lane_mask = 4'h3;
            `LSR_CFG_S16X4: lsr_lane_mask = 4'hF;
            default:        lsr_lane_mask = 4'h1;
        endcase
    end
endfunction

wire [`LSR_RAM_AW-1:0] wr_addr;
wire [`LSR_RAM_AW-1:0] rd2_addr;
wire [`LSR_RAM_DW-1:0] lane_en;

assign wr_addr  = lsr_mask_addr(ram_config, ram_address);
assign rd2_addr = lsr_mask_addr(ram_config, second_read_address);
assign lane_en  = lsr_lane_mask(ram_config);

////////////////////////////////////////////////////////////////////////////////
// Storage: one 64x1 cell array per data lane

// High in the dual-port configuration
function lsr_is_dual;
    input [`LSR_CFG_W-1:0] cfg;
    begin
        lsr_is_dual = (cfg == `LSR_CFG_D16X1);
    end
endfunction

// One cell of a lane at an address
function lsr_cell;
    input [`LSR_RAM_CELLS-1:0] lane;
    input [`LSR_RAM_AW-1:0]    addr;
    begin
        lsr_cell = lane[addr];
    end
endfunction

// Lane contents after an optional write of one cell
function [`LSR_RAM_CELLS-1:0] lsr_write_cell;
    input [`LSR_RAM_CELLS-1:0] lane;
    input [`LSR_RAM_AW-1:0]    addr;
    input                      bit_in;
    input                      wr_en;
    begin
        lsr_write_cell = lane;
        if (wr_en) begin
            lsr_write_cell[addr] = bit_in;
        end
    end
endfunction

wire dual_mode;
wire lane0_we;
wire lane1_we;
wire lane2_we;
wire lane3_we;

// Lane write enables: strobe gated by lanes in use
assign dual_mode = lsr_is_dual(ram_config);
assign lane0_we  = ram_write_strobe & lane_en[0];
assign lane1_we  = ram_write_strobe & lane_en[1];
assign lane2_we  = ram_write_strobe & lane_en[2];
assign lane3_we  = ram_write_strobe & lane_en[3];

reg  [`LSR_RAM_CELLS-1:0] lane0_r;
reg  [`LSR_RAM_CELLS-1:0] lane1_r;
reg  [`LSR_RAM_CELLS-1:0] lane2_r;
reg  [`LSR_RAM_CELLS-1:0] lane3_r;
wire [`LSR_RAM_CELLS-1:0] lane0_nxt;
wire [`LSR_RAM_CELLS-1:0] lane1_nxt;
wire [`LSR_RAM_CELLS-1:0] lane2_nxt;
wire [`LSR_RAM_CELLS-1:0] lane3_nxt;

initial begin
    lane0_r = RAM_INIT;
    lane1_r = RAM_INIT;
    lane2_r = RAM_INIT;
    lane3_r = RAM_INIT;
end

// Next lane contents, one addressed cell at most
assign lane0_nxt = lsr_write_cell(lane0_r, wr_addr,
                                  ram_data_in[0], lane0_we);
assign lane1_nxt = lsr_write_cell(lane1_r, wr_addr,
                                  ram_data_in[1], lane1_we);
assign lane2_nxt = lsr_write_cell(lane2_r, wr_addr,
                                  ram_data_in[2], lane2_we);
assign lane3_nxt = lsr_write_cell(lane3_r, wr_addr,
                                  ram_data_in[3], lane3_we);

// Reset deliberately absent: contents survive rst_b

// Lane 0: used by every configuration
always @(posedge clk_sys) begin
    lane0_r <= lane0_nxt;
end

// Lane 1: two and four bit wide modes
always @(posedge clk_sys) begin
    lane1_r <= lane1_nxt;
end

// Lane 2: four bit wide mode only
always @(posedge clk_sys) begin
    lane2_r <= lane2_nxt;
end

// Lane 3: four bit wide mode only
always @(posedge clk_sys) begin
    lane3_r <= lane3_nxt;
end

////////////////////////////////////////////////////////////////////////////////
// Asynchronous reads

wire                   rd_lane0;
wire                   rd_lane1;
wire                   rd_lane2;
wire                   rd_lane3;
wire                   rd2_lane0;
wire [`LSR_RAM_DW-1:0] rd_word;

// Primary port reads the write address
assign rd_lane0  = lsr_cell(lane0_r, wr_addr);
assign rd_lane1  = lsr_cell(lane1_r, wr_addr);
assign rd_lane2  = lsr_cell(lane2_r, wr_addr);
assign rd_lane3  = lsr_cell(lane3_r, wr_addr);

// Second port reads the same lane 0 cells
assign rd2_lane0 = lsr_cell(lane0_r, rd2_addr);

assign rd_word = {rd_lane3, rd_lane2, rd_lane1, rd_lane0};

// Unused lanes and idle second port read zero
assign primary_read_out   = rd_word & lane_en;
assign secondary_read_out = dual_mode ? rd2_lane0 : 1'b0;

endmodule // lsr_lut_memory

/* verif/lsr_checker.sv */
`timescale 1ns/100ps
module lsr_checker (input logic clk_sys, rst_b, shift_write_strobe,
    serial_bit_in, tap_out, last_stage_out, ram_write_strobe,
    secondary_read_out, logic [3:0] tap_address, ram_data_in,
    primary_read_out, logic [2:0] ram_config,
    logic [5:0] ram_address, second_read_address);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    tap_zero_a: assert property (shift_write_strobe && !tap_address ##1
        !tap_address |-> tap_out == $past(serial_bit_in)) else $error("tap0");
    deep_a: assert property (shift_write_strobe && tap_address == 14
        |=> last_stage_out == $past(tap_out)) else $error("deep");
    hold_a: assert property (!shift_write_strobe |=>
        $stable(last_stage_out)) else $error("hold");
    tap_last_a: assert property (tap_address == 15 |->
        tap_out == last_stage_out) else $error("tap15");
    wide_a: assert property (ram_write_strobe && ram_config == 6 ##1
        $stable(ram_address) && ram_config == 6
        |-> primary_read_out == $past(ram_data_in)) else $error("wide");
    lane_a: assert property (ram_config == 0 |->
        primary_read_out[3:1] == 3'h0) else $error("lane");
    keep_a: assert property (!ram_write_strobe ##1
        $stable(ram_address) && $stable(ram_config)
        |-> $stable(primary_read_out)) else $error("keep");
    dual_a: assert property (ram_config == 3 &&
        second_read_address[3:0] == ram_address[3:0] |->
        secondary_read_out == primary_read_out[0]) else $error("dual");
    cover property (shift_write_strobe [*8]);
    cover property (ram_write_strobe && ram_config == 3);
    cover property (ram_write_strobe && ram_config == 6);
endmodule // lsr_checker

/* verif/lsr_user_logic.sv */
`timescale 1ns/100ps
module lsr_user_logic (input wire clk_sys, output reg shift_write_strobe = 0,
    serial_bit_in = 0, ram_write_strobe = 0, reg [2:0] ram_config = 0,
    reg [5:0] ram_address = 0, reg [3:0] ram_data_in = 0);
    task shift(input logic we, b);
        @(negedge clk_sys) {shift_write_strobe, serial_bit_in} = {we, b};
        @(posedge clk_sys);
    endtask
    task write(input logic we, logic [2:0] c, logic [5:0] a, logic [3:0] d);
        @(negedge clk_sys) {ram_write_strobe, ram_config, ram_address,
            ram_data_in} = {we, c, a, d};
        @(posedge clk_sys);
    endtask
endmodule // lsr_user_logic

/* verif/tb_lsr_lut_memory.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_lsr_lut_memory;
    logic clk_sys = 0, rst_b = 0, shift_write_strobe, serial_bit_in, tap_out;
    logic last_stage_out, ram_write_strobe, secondary_read_out;
    logic [2:0] ram_config;
    logic [3:0] tap_address = 0, ram_data_in, primary_read_out, m;
    logic [5:0] ram_address, second_read_address = 0;
    logic [15:0] pat = 16'hA5C3;
    int num_errors, total_checks, cyc;
    always #2.5 clk_sys = ~clk_sys;
    lsr_user_logic u_lsr_user_logic (.*);
    lsr_lut_memory u_lsr_lut_memory (.*);
    always @(posedge clk_sys) if (++cyc == 500) begin
        num_errors++;
        give_verdict;
    end
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task t_shift;
        for (int i = 0; i < 16; i++) begin
            u_lsr_user_logic.shift(1, pat[i]);
            #1 `CHK("tap0", pat[i], tap_out)
        end
        u_lsr_user_logic.shift(0, 0);
        for (int k = 0; k < 16; k++) begin
            @(negedge clk_sys) tap_address = k[3:0];
            #1 `CHK("tap", pat[15 - k], tap_out)
        end
        `CHK("last", pat[0], last_stage_out)
        @(negedge clk_sys) tap_address = 4'hE;
        u_lsr_user_logic.shift(1, 1);
        #1 `CHK("deep", pat[1], last_stage_out)
        u_lsr_user_logic.shift(0, 0);
        #1 `CHK("stay", pat[1], last_stage_out)
        $display("shift test done");
    endtask
    task t_ram;
        for (logic [2:0] c = 0; c < 7; c++) begin
            u_lsr_user_logic.write(1, c, 6'h2A + c, 4'hA ^ c);
            u_lsr_user_logic.write(0, c, 6'h2A + c, 4'h5 ^ c);
            m = (4'hA ^ c) & {c == 6, c == 6, c > 3, 1'h1};
            #1 `CHK("ram", m, primary_read_out)
            @(negedge clk_sys) second_read_address = 6'h2A + c;
            #1 `CHK("dual", c == 3, secondary_read_out)
        end
        @(negedge clk_sys) rst_b = 0;
        @(negedge clk_sys) rst_b = 1;
        #1 `CHK("held", 4'hC, primary_read_out)
        $display("ram test done");
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_b = 1;
        `CHK("init", 4'h0, primary_read_out)
        t_shift;
        t_ram;
        give_verdict;
    end
endmodule // tb_lsr_lut_memory
bind lsr_lut_memory lsr_checker u_lsr_checker (.*);
